// ===== rtl/fhp_params.svh
`ifndef FHP_PARAMS_SVH
`define FHP_PARAMS_SVH

`define FHP_DATA_W 8
`define FHP_INDEX_W 5
`define FHP_PIN_W 18
// Packed pin vector: reset_n, cs_n, strobe_n, dir, style, index, data
`define FHP_PIN_RSTN 17
`define FHP_PIN_CSN 16
`define FHP_PIN_STBN 15
`define FHP_PIN_DIR 14
`define FHP_PIN_STYLE 13
`define FHP_PIN_IDX_HI 12
`define FHP_PIN_IDX_LO 8
`define FHP_PIN_DAT_HI 7
`define FHP_PIN_DAT_LO 0
// Pins at rest: device reset held, selects and strobes high
`define FHP_PIN_RESET 18'h1_C000
`define FHP_DATA_RESET 8'h00
`define FHP_INDEX_RESET 5'h00

`endif

// ===== rtl/fhp_pkg.sv
`default_nettype none

package fhp_pkg;

    typedef enum logic [1:0] {
        FHP_IDLE,
        FHP_READ,
        FHP_WRITE
    } fhp_state_t;

endpackage

`default_nettype wire

// ===== rtl/fhp_host_port.sv
// Behaviour
// - Port answers only while chip-select is low
// - Deselected: port idle, bus lines released
// - Direction style: shared strobe qualifies each access
// - Separate style: shared strobe is read strobe
// - Style pin high separate, low direction
// - Eight data lines, line 0 least significant
// - Interrupt pin pulled low while request pending
// - Interrupt pin open drain, never drives high
// - Interrupt works regardless of chip-select
// - Reset pin low holds device in reset
// - Direction line high reads, low writes
// - Separate style: same pin is write strobe
// - Five index lines pick the location
`timescale 1ns/1ps
`default_nettype none
`include "fhp_params.svh"

module fhp_host_port (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic cs_n,
    input wire logic shared_access_strobe_n,
    input wire logic dir_or_write_strobe,
    input wire logic bus_style_select,
    input wire logic device_reset_n,
    input wire logic [`FHP_INDEX_W-1:0] register_index_lines,
    input wire logic [`FHP_DATA_W-1:0] host_bus_lines_in,
    output logic [`FHP_DATA_W-1:0] host_bus_lines_out,
    output logic host_bus_lines_oe,
    output logic irq_n_out,
    output logic irq_n_oe,
    input wire logic irq_pending,
    input wire logic [`FHP_DATA_W-1:0] reg_rdata,
    output logic [`FHP_INDEX_W-1:0] reg_index,
    output logic [`FHP_DATA_W-1:0] reg_wdata,
    output logic reg_rd_pulse,
    output logic reg_wr_pulse,
    output logic reset_hold
);

    // Read request for the selected strobe style
    function automatic logic read_req(input logic style, input logic stb_n,
                                      input logic dir);
        read_req = style ? !stb_n : (!stb_n && dir);
    endfunction

    // Write request for the selected strobe style
    function automatic logic write_req(input logic style, input logic stb_n,
                                       input logic dir);
        write_req = style ? !dir : (!stb_n && !dir);
    endfunction

    logic [`FHP_PIN_W-1:0] meta_reg;
    logic [`FHP_PIN_W-1:0] pin_reg;
    logic [`FHP_PIN_W-1:0] pin_next;

    fhp_pkg::fhp_state_t state_reg;
    fhp_pkg::fhp_state_t state_next;
    logic [`FHP_DATA_W-1:0] dout_reg;
    logic [`FHP_DATA_W-1:0] dout_next;
    logic oe_reg;
    logic oe_next;
    logic [`FHP_INDEX_W-1:0] index_reg;
    logic [`FHP_INDEX_W-1:0] index_next;
    logic [`FHP_DATA_W-1:0] wdata_reg;
    logic [`FHP_DATA_W-1:0] wdata_next;
    logic rd_reg;
    logic rd_next;
    logic wr_reg;
    logic wr_next;
    logic irq_oe_reg;
    logic irq_oe_next;
    logic irq_out_reg;
    logic hold_reg;
    logic hold_next;

    logic rstn_s;
    logic sel_s;
    logic style_s;
    logic stb_s;
    logic dir_s;
    logic rd_req_s;
    logic wr_req_s;
    logic [`FHP_INDEX_W-1:0] idx_s;
    logic [`FHP_DATA_W-1:0] data_s;

    // Two-stage synchroniser for every pin
    always_comb
    begin
        pin_next = {device_reset_n, cs_n, shared_access_strobe_n,
                    dir_or_write_strobe, bus_style_select,
                    register_index_lines, host_bus_lines_in};
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            meta_reg <= `FHP_PIN_RESET;
            pin_reg <= `FHP_PIN_RESET;
        end
        else if (clk_en)
        begin
            meta_reg <= pin_next;
            pin_reg <= meta_reg;
        end
    end

    assign rstn_s = pin_reg[`FHP_PIN_RSTN];
    assign style_s = pin_reg[`FHP_PIN_STYLE];
    assign stb_s = pin_reg[`FHP_PIN_STBN];
    assign dir_s = pin_reg[`FHP_PIN_DIR];
    assign idx_s = pin_reg[`FHP_PIN_IDX_HI:`FHP_PIN_IDX_LO];
    assign data_s = pin_reg[`FHP_PIN_DAT_HI:`FHP_PIN_DAT_LO];
    assign sel_s = !pin_reg[`FHP_PIN_CSN] && rstn_s;
    assign rd_req_s = read_req(style_s, stb_s, dir_s);
    assign wr_req_s = write_req(style_s, stb_s, dir_s);

    always_comb
    begin
        state_next = state_reg;
        dout_next = dout_reg;
        oe_next = 1'b0;
        index_next = index_reg;
        wdata_next = wdata_reg;
        rd_next = 1'b0;
        wr_next = 1'b0;
        irq_oe_next = irq_pending;
        hold_next = !rstn_s;
        if (!rstn_s)
        begin
            state_next = fhp_pkg::FHP_IDLE;
        end
        else
        begin
            case (state_reg)
                fhp_pkg::FHP_IDLE:
                begin
                    if (sel_s && rd_req_s)
                    begin
                        index_next = idx_s;
                        rd_next = 1'b1;
                        state_next = fhp_pkg::FHP_READ;
                    end
                    else if (sel_s && wr_req_s)
                    begin
                        index_next = idx_s;
                        wdata_next = data_s;
                        state_next = fhp_pkg::FHP_WRITE;
                    end
                end
                fhp_pkg::FHP_READ:
                begin
                    if (sel_s && rd_req_s)
                    begin
                        oe_next = 1'b1;
                        dout_next = reg_rdata;
                    end
                    else
                    begin
                        state_next = fhp_pkg::FHP_IDLE;
                    end
                end
                fhp_pkg::FHP_WRITE:
                begin
                    if (sel_s && wr_req_s)
                    begin
                        index_next = idx_s;
                        wdata_next = data_s;
                    end
                    else
                    begin
                        // Commit at the trailing edge of the access
                        wr_next = 1'b1;
                        state_next = fhp_pkg::FHP_IDLE;
                    end
                end
                default:
                begin
                    state_next = fhp_pkg::FHP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= fhp_pkg::FHP_IDLE;
            dout_reg <= `FHP_DATA_RESET;
            oe_reg <= 1'b0;
            index_reg <= `FHP_INDEX_RESET;
            wdata_reg <= `FHP_DATA_RESET;
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            irq_oe_reg <= 1'b0;
            irq_out_reg <= 1'b0;
            hold_reg <= 1'b1;
        end
        else if (clk_en)
        begin
            state_reg <= state_next;
            dout_reg <= dout_next;
            oe_reg <= oe_next;
            index_reg <= index_next;
            wdata_reg <= wdata_next;
            rd_reg <= rd_next;
            wr_reg <= wr_next;
            irq_oe_reg <= irq_oe_next;
            irq_out_reg <= 1'b0;
            hold_reg <= hold_next;
        end
    end

    assign host_bus_lines_out = dout_reg;
    assign host_bus_lines_oe = oe_reg;
    assign irq_n_out = irq_out_reg;
    assign irq_n_oe = irq_oe_reg;
    assign reg_index = index_reg;
    assign reg_wdata = wdata_reg;
    assign reg_rd_pulse = rd_reg;
    assign reg_wr_pulse = wr_reg;
    assign reset_hold = hold_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic idle_s;
    assign idle_s = (state_reg == fhp_pkg::FHP_IDLE);

    a_deselect_idle: assert property (
        (clk_en && !sel_s) |=> !host_bus_lines_oe && !reg_rd_pulse)
        else $error("Bus driven or read issued while deselected");
    a_read_needs_select: assert property (
        reg_rd_pulse |-> $past(sel_s && rd_req_s))
        else $error("Read pulse without selected read request");
    a_drive_only_read: assert property (
        host_bus_lines_oe |-> $past(sel_s && rd_req_s)
            && state_reg == fhp_pkg::FHP_READ)
        else $error("Bus driven outside a selected read");
    a_separate_read: assert property (
        (clk_en && idle_s && sel_s && style_s && !stb_s)
            |=> reg_rd_pulse ##0 state_reg == fhp_pkg::FHP_READ)
        else $error("Read strobe did not start a read");
    a_direction_write: assert property (
        (clk_en && idle_s && sel_s && !style_s && !stb_s && !dir_s)
            |=> state_reg == fhp_pkg::FHP_WRITE && !reg_rd_pulse)
        else $error("Low direction line did not start a write");
    a_strobe_qualify: assert property (
        (clk_en && idle_s && !style_s && stb_s) |=> idle_s && !reg_rd_pulse)
        else $error("Access started without data strobe");
    a_write_strobe: assert property (
        (clk_en && idle_s && sel_s && style_s && stb_s && !dir_s)
            |=> state_reg == fhp_pkg::FHP_WRITE ##1 !host_bus_lines_oe)
        else $error("Write strobe did not start a write");
    a_irq_follows: assert property (
        clk_en |=> irq_n_oe == $past(irq_pending))
        else $error("Interrupt pin does not follow pending request");
    a_irq_open_drain: assert property (
        irq_n_out == 1'b0)
        else $error("Interrupt pin would drive high");
    a_irq_no_select: assert property (
        (clk_en && irq_pending && cs_n) |=> irq_n_oe)
        else $error("Interrupt blocked by chip-select");
    a_reset_pin: assert property (
        (clk_en && !rstn_s) |=> reset_hold && idle_s && !host_bus_lines_oe)
        else $error("Reset pin did not hold the port in reset");
    a_index_capture: assert property (
        (clk_en && idle_s && sel_s && rd_req_s) |=> reg_index == $past(idx_s))
        else $error("Index not captured at read start");
    a_read_data: assert property (
        (clk_en && state_reg == fhp_pkg::FHP_READ && sel_s && rd_req_s)
            |=> host_bus_lines_out == $past(reg_rdata))
        else $error("Read data not placed on the bus");

    c_read: cover property (reg_rd_pulse ##1 host_bus_lines_oe);
    c_write: cover property (state_reg == fhp_pkg::FHP_WRITE ##1 reg_wr_pulse);
    c_irq_deselected: cover property (irq_n_oe && cs_n);
    c_pin_reset: cover property (reset_hold ##1 !reset_hold);

endmodule // fhp_host_port

`default_nettype wire

// ===== test/fhp_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module fhp_cpu_model (
    input wire logic clk_sys,
    output logic cs_n,
    output logic stb_n,
    output logic dir,
    output logic style,
    output logic dev_rst_n,
    output logic [4:0] idx,
    output logic [7:0] bus,
    input wire logic [7:0] dut_out,
    input wire logic dut_oe
);
    logic [7:0] wd;
    logic wd_oe;
    logic [7:0] last = 8'h00;

    // Undriven bus shows the inverse of its last value
    always_comb bus = dut_oe ? dut_out : (wd_oe ? wd : ~last);

    always @(posedge clk_sys) last <= bus;

    initial
    begin
        cs_n = 1'b1;
        stb_n = 1'b1;
        dir = 1'b1;
        style = 1'b1;
        dev_rst_n = 1'b0;
        idx = 5'h00;
        wd = 8'h00;
        wd_oe = 1'b0;
    end

    task automatic hold_reset(input int n);
        dev_rst_n = 1'b0;
        repeat (n) @(negedge clk_sys);
        dev_rst_n = 1'b1;
    endtask

    task automatic access(input logic sel, input logic st, input logic rd,
        input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge clk_sys);
        style = st;
        @(negedge clk_sys);
        cs_n = !sel;
        idx = a;
        wd = d;
        wd_oe = !rd;
        stb_n = st ? !rd : 1'b0;
        dir = rd;
        repeat (8) @(negedge clk_sys);
        q = bus;
        cs_n = 1'b1;
        stb_n = 1'b1;
        dir = 1'b1;
        wd_oe = 1'b0;
        repeat (6) @(negedge clk_sys);
    endtask
endmodule // fhp_cpu_model

`default_nettype wire

// ===== test/fhp_host_port_bench.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) \
        begin \
            $display("ERROR %s expected %h seen %h", n, e, g); \
            err_count++; \
        end \
    end

module fhp_host_port_bench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic irq_pending = 1'b0;
    logic [7:0] reg_rdata = 8'h00;
    logic [7:0] q;
    wire logic cs_n, stb_n, dir, style, dev_rst_n, oe, irq_out, irq_oe;
    wire logic rdp, wrp, hold;
    wire logic [4:0] idx, r_idx;
    wire logic [7:0] bus, out, r_wd;
    int err_count = 0;
    int samples_checked = 0;
    int rd_cnt, wr_cnt, oe_cnt;
    int cyc = 0;
    logic [4:0] cap_idx;
    logic [7:0] cap_wd;
    wire logic irq_line = irq_oe ? irq_out : 1'b1; // Pull-up

    fhp_cpu_model cpu (.clk_sys(clk_sys), .cs_n(cs_n), .stb_n(stb_n),
        .dir(dir), .style(style), .dev_rst_n(dev_rst_n), .idx(idx),
        .bus(bus), .dut_out(out), .dut_oe(oe));

    fhp_host_port dut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
        .cs_n(cs_n), .shared_access_strobe_n(stb_n),
        .dir_or_write_strobe(dir), .bus_style_select(style),
        .device_reset_n(dev_rst_n), .register_index_lines(idx),
        .host_bus_lines_in(bus), .host_bus_lines_out(out),
        .host_bus_lines_oe(oe), .irq_n_out(irq_out), .irq_n_oe(irq_oe),
        .irq_pending(irq_pending), .reg_rdata(reg_rdata),
        .reg_index(r_idx), .reg_wdata(r_wd), .reg_rd_pulse(rdp),
        .reg_wr_pulse(wrp), .reset_hold(hold));

    always #5 clk_sys = ~clk_sys;

    always @(negedge clk_sys)
    begin
        if (rdp !== 1'b0)
        begin
            rd_cnt++;
            cap_idx = r_idx;
        end
        if (wrp !== 1'b0)
        begin
            wr_cnt++;
            cap_idx = r_idx;
            cap_wd = r_wd;
        end
        if (oe !== 1'b0)
            oe_cnt++;
    end

    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            final_report();
        end
    end

    task automatic clr();
        rd_cnt = 0;
        wr_cnt = 0;
        oe_cnt = 0;
    endtask

    task automatic t_read(input logic st, input logic [4:0] a,
        input logic [7:0] d);
        @(negedge clk_sys);
        reg_rdata = d;
        clr();
        cpu.access(1'b1, st, 1'b1, a, 8'h00, q);
        `CHK("rd pulses", 1, rd_cnt)
        `CHK("rd index", a, cap_idx)
        `CHK("rd data", d, q)
        `CHK("rd wr pulses", 0, wr_cnt)
        `CHK("rd oe end", 1'b0, oe)
    endtask

    task automatic t_write(input logic st, input logic [4:0] a,
        input logic [7:0] d);
        clr();
        cpu.access(1'b1, st, 1'b0, a, d, q);
        `CHK("wr pulses", 1, wr_cnt)
        `CHK("wr data", d, cap_wd)
        `CHK("wr index", a, cap_idx)
        `CHK("wr oe", 0, oe_cnt + rd_cnt)
    endtask

    task automatic t_desel(input logic st, input logic rd);
        clr();
        cpu.access(1'b0, st, rd, 5'h0A, 8'h3C, q);
        `CHK("desel access", 0, rd_cnt + wr_cnt + oe_cnt)
    endtask

    task automatic t_irq();
        @(negedge clk_sys);
        irq_pending = 1'b1;
        repeat (3) @(negedge clk_sys);
        `CHK("irq low", 1'b0, irq_line)
        `CHK("irq drive", 1'b0, irq_out)
        irq_pending = 1'b0;
        repeat (3) @(negedge clk_sys);
        `CHK("irq free", 1'b1, irq_line)
    endtask

    task automatic t_freeze();
        @(negedge clk_sys);
        clk_en = 1'b0;
        irq_pending = 1'b1;
        repeat (4) @(negedge clk_sys);
        `CHK("frozen irq", 1'b1, irq_line)
        clk_en = 1'b1;
        repeat (3) @(negedge clk_sys);
        `CHK("thawed irq", 1'b0, irq_line)
        irq_pending = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask

    task automatic t_devrst();
        clr();
        fork
            cpu.hold_reset(100);
            begin
                repeat (10) @(negedge clk_sys);
                `CHK("hold", 1'b1, hold)
                cpu.access(1'b1, 1'b1, 1'b1, 5'h05, 8'h00, q);
            end
        join
        repeat (5) @(negedge clk_sys);
        `CHK("hold off", 1'b0, hold)
        `CHK("rst access", 0, rd_cnt + oe_cnt)
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        cpu.hold_reset(100);
        repeat (5) @(negedge clk_sys);
        t_read(1'b1, 5'h13, 8'hA5);
        t_read(1'b0, 5'h01, 8'h80);
        t_write(1'b0, 5'h1F, 8'h01);
        t_write(1'b1, 5'h10, 8'h5A);
        t_desel(1'b1, 1'b1);
        t_desel(1'b0, 1'b0);
        t_irq();
        t_freeze();
        t_devrst();
        t_read(1'b1, 5'h00, 8'hFF);
        final_report();
    end
endmodule // fhp_host_port_bench

`default_nettype wire
